// ---- logic/sars_pkg.sv ----
// Constants, timing counts and state types for the serial converter sequencer.
// Assumes a 10 MHz system clock; the shift clock comes from the host.
package sars_pkg;
   localparam int RES_BITS = 10;
   localparam int SYS_PERIOD_NS = 100;
   localparam int SETUP_NS = 1425;
   localparam int SETUP_CYC = (SETUP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int CONV_US = 21;
   localparam int CONV_CYC = (CONV_US * 1000) / SYS_PERIOD_NS;
   localparam int ABORT_US = 9;
   localparam int ABORT_CYC = (ABORT_US * 1000) / SYS_PERIOD_NS;
   localparam int STEP_CYC = (CONV_CYC - 2) / RES_BITS;
   localparam int FLT_W = 4;
   localparam int TMR_W = 8;
   localparam int EDGE_W = 5;
   localparam int BIT_W = 4;
   localparam logic [EDGE_W-1:0] EDGE_MAX = 5'h10;
   localparam logic [EDGE_W-1:0] EDGE_SAMPLE_START = 5'h03;
   localparam logic [EDGE_W-1:0] EDGE_SAMPLE_END = 5'h0A;
   localparam logic [FLT_W-1:0] FLT_LAST = FLT_W'(SETUP_CYC - 1);
   localparam logic [TMR_W-1:0] ABORT_LAST = TMR_W'(ABORT_CYC - 1);
   localparam logic [TMR_W-1:0] STEP_LAST = TMR_W'(STEP_CYC - 1);
   localparam logic [BIT_W-1:0] BIT_MSB = BIT_W'(RES_BITS - 1);
   localparam logic [RES_BITS-1:0] CODE_ONES = 10'h3FF;
   localparam logic [RES_BITS-1:0] CODE_ZEROS = 10'h000;
   localparam logic [RES_BITS-1:0] CODE_ONE = 10'h001;
   typedef enum {SEQ_IDLE, SEQ_ACCESS, SEQ_CONVERT} sars_seq_t;
   typedef enum {SAR_IDLE, SAR_STEP} sars_sar_t;
endpackage : sars_pkg

// ---- logic/sars_approx.sv ----
// Successive-approximation engine: one trial bit per step, MSB first.
// Assumes a comparator outside that reports whether the held input exceeds the trial code.
`timescale 1ns/1ns
module sars_approx
   import sars_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_start,
   input wire logic i_abort,
   input wire logic i_cmp_high,
   input wire logic i_above_ref,
   input wire logic i_below_ref,
   output logic [RES_BITS-1:0] o_dac_code,
   output logic [RES_BITS-1:0] o_code,
   output logic o_done
);
   sars_sar_t state, next_state;
   logic [BIT_W-1:0] bit_idx, next_bit_idx;
   logic [TMR_W-1:0] step_tmr, next_step_tmr;
   logic [RES_BITS-1:0] code, next_code;
   logic [RES_BITS-1:0] next_dac_code, next_out_code;
   logic above, next_above, below, next_below, next_done;
   logic [RES_BITS-1:0] kept;

   always_comb begin
      next_state = state;
      next_bit_idx = bit_idx;
      next_step_tmr = step_tmr;
      next_code = code;
      next_above = above;
      next_below = below;
      next_dac_code = o_dac_code;
      next_out_code = o_code;
      next_done = 1'b0;
      kept = i_cmp_high ? o_dac_code : code;
      unique case (state)
         SAR_IDLE: begin
            if (i_start) begin
               next_state = SAR_STEP;
               next_bit_idx = BIT_MSB;
               next_step_tmr = '0;
               next_code = CODE_ZEROS;
               next_above = i_above_ref;
               next_below = i_below_ref;
               next_dac_code = CODE_ONE << BIT_MSB;
            end
         end
         SAR_STEP: begin
            next_step_tmr = step_tmr + 1'b1;
            if (i_abort) begin
               next_state = SAR_IDLE;
            end else if (step_tmr == STEP_LAST) begin
               next_step_tmr = '0;
               next_code = kept;
               if (bit_idx == '0) begin
                  next_state = SAR_IDLE;
                  next_done = 1'b1;
                  // Out-of-range inputs clamp rather than wrap
                  next_out_code = above ? CODE_ONES : (below ? CODE_ZEROS : kept);
               end else begin
                  next_bit_idx = bit_idx - 1'b1;
                  next_dac_code = kept | (CODE_ONE << (bit_idx - 1'b1));
               end
            end
         end
      endcase
   end

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= SAR_IDLE;
         bit_idx <= '0;
         step_tmr <= '0;
         code <= CODE_ZEROS;
         above <= 1'b0;
         below <= 1'b0;
         o_dac_code <= CODE_ZEROS;
         o_code <= CODE_ZEROS;
         o_done <= 1'b0;
      end else begin
         state <= next_state;
         bit_idx <= next_bit_idx;
         step_tmr <= next_step_tmr;
         code <= next_code;
         above <= next_above;
         below <= next_below;
         o_dac_code <= next_dac_code;
         o_code <= next_out_code;
         o_done <= next_done;
      end
   end
endmodule : sars_approx

// ---- logic/sars_sequencer.sv ----
// Readout sequencer of a 10-bit serial converter: select filter, shift-clock edge count,
// sample window, conversion timing, abort window and three-state result output.
// Assumes the host drives select and the shift clock; the shift clock may stop between frames.
//
// Overview of operation
// - Shift clock is ignored until select has been low for the filtered setup time.
// - A select level counts only after holding steady for the 1.425 us setup.
// - Sampling runs from the third to the tenth falling shift-clock edge.
// - Conversion ends within 21 us of the tenth edge.
// - Select falling within 9 us after the tenth edge aborts the conversion.
// - Select low drives the MSB onto the output within 1.3 us.
// - Select high returns the output to high impedance promptly.
// - Inputs beyond the references give all-ones or all-zeros codes.
// - Select fall starts each cycle; an abort keeps the previous result.
`timescale 1ns/1ns
module sars_sequencer
   import sars_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_io_clock,
   input wire logic i_select_n,
   input wire logic i_cmp_high,
   input wire logic i_above_ref,
   input wire logic i_below_ref,
   output logic o_data,
   output logic o_data_oe_n,
   output logic [RES_BITS-1:0] o_dac_code,
   output logic o_sampling,
   output logic o_busy
);
   logic rst_meta, rst_n;
   logic sel_meta, sel_sync;
   logic sel_stable, next_sel_stable;
   logic [FLT_W-1:0] flt_cnt, next_flt_cnt;
   sars_seq_t state, next_state;
   logic [TMR_W-1:0] tmr, next_tmr;
   logic link_en, next_link_en;
   logic [RES_BITS-1:0] result, next_result;
   logic next_data, next_oe_n, next_sampling, next_busy;
   logic sar_start, sar_abort, sar_done;
   logic [RES_BITS-1:0] sar_code;
   logic sel_fall, sel_rise;
   logic [EDGE_W-1:0] gray_meta, gray_sync, edges;
   logic link_rst_n;
   logic [EDGE_W-1:0] lcnt, next_lcnt, lgray;

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         sel_meta <= 1'b1;
         sel_sync <= 1'b1;
         gray_meta <= '0;
         gray_sync <= '0;
      end else begin
         sel_meta <= i_select_n;
         sel_sync <= sel_meta;
         gray_meta <= lgray;
         gray_sync <= gray_meta;
      end
   end

   always_comb begin
      edges[EDGE_W-1] = gray_sync[EDGE_W-1];
      for (int i = EDGE_W - 2; i >= 0; i--) begin
         edges[i] = edges[i+1] ^ gray_sync[i];
      end
   end

   // A level must persist the whole setup time before it counts, which rejects glitches
   always_comb begin
      next_sel_stable = sel_stable;
      next_flt_cnt = '0;
      if (sel_sync != sel_stable) begin
         if (flt_cnt == FLT_LAST) begin
            next_sel_stable = sel_sync;
         end else begin
            next_flt_cnt = flt_cnt + 1'b1;
         end
      end
   end

   assign sel_fall = sel_stable && !next_sel_stable;
   assign sel_rise = !sel_stable && next_sel_stable;

   always_comb begin
      next_state = state;
      next_tmr = tmr;
      next_result = result;
      sar_start = 1'b0;
      sar_abort = 1'b0;
      unique case (state)
         SEQ_IDLE: begin
            if (sel_fall) begin
               next_state = SEQ_ACCESS;
            end
         end
         SEQ_ACCESS: begin
            if (edges >= EDGE_SAMPLE_END) begin
               next_state = SEQ_CONVERT;
               next_tmr = '0;
               sar_start = 1'b1;
            end else if (sel_rise) begin
               next_state = SEQ_IDLE;
            end
         end
         SEQ_CONVERT: begin
            if (tmr != ABORT_LAST + 1'b1) begin
               next_tmr = tmr + 1'b1;
            end
            if (sel_fall && tmr <= ABORT_LAST) begin
               next_state = SEQ_IDLE;
               sar_abort = 1'b1;
            end else if (sar_done) begin
               next_state = SEQ_IDLE;
               next_result = sar_code;
            end
         end
      endcase
   end

   always_comb begin
      next_link_en = (next_state != SEQ_IDLE) && !next_sel_stable;
      next_sampling = (state == SEQ_ACCESS) && (edges >= EDGE_SAMPLE_START) &&
         (edges < EDGE_SAMPLE_END);
      next_busy = next_state != SEQ_IDLE;
      // Output drive follows the synchronised pin, not the filter, to meet the enable time
      next_oe_n = sel_sync;
      next_data = 1'b0;
      if (edges < EDGE_W'(RES_BITS)) begin
         next_data = result[BIT_MSB - edges[BIT_W-1:0]];
      end
   end

   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         sel_stable <= 1'b1;
         flt_cnt <= '0;
         state <= SEQ_IDLE;
         tmr <= '0;
         result <= CODE_ZEROS;
         link_en <= 1'b0;
         o_sampling <= 1'b0;
         o_busy <= 1'b0;
         o_data_oe_n <= 1'b1;
         o_data <= 1'b0;
      end else begin
         sel_stable <= next_sel_stable;
         flt_cnt <= next_flt_cnt;
         state <= next_state;
         tmr <= next_tmr;
         result <= next_result;
         link_en <= next_link_en;
         o_sampling <= next_sampling;
         o_busy <= next_busy;
         o_data_oe_n <= next_oe_n;
         o_data <= next_data;
      end
   end

   sars_approx u_approx (
      .i_clock(i_clock),
      .i_rst_n(rst_n),
      .i_start(sar_start),
      .i_abort(sar_abort),
      .i_cmp_high(i_cmp_high),
      .i_above_ref(i_above_ref),
      .i_below_ref(i_below_ref),
      .o_dac_code(o_dac_code),
      .o_code(sar_code),
      .o_done(sar_done)
   );

   // Link side is cleared by the frame itself, since its clock may stop outside frames
   // Release is left unsynchronised so no host edge is lost; the shift clock stands
   // still then, because the host holds off for the select setup time
   assign link_rst_n = link_en;

   always_comb begin
      next_lcnt = lcnt;
      if (lcnt != EDGE_MAX) begin
         next_lcnt = lcnt + 1'b1;
      end
   end

   // Only the gray copy crosses, so a sampled count is never off by more than one edge
   always_ff @(negedge i_io_clock or negedge link_rst_n) begin
      if (!link_rst_n) begin
         lcnt <= '0;
         lgray <= '0;
      end else begin
         lcnt <= next_lcnt;
         lgray <= next_lcnt ^ (next_lcnt >> 1);
      end
   end
endmodule : sars_sequencer

// ---- sim/sars_host.sv ----
// Host serial port master model: select and short 3 ns low shift-clock pulses.
// Assumes the bench sequences calls; the shift clock stands still high between bursts.
`timescale 1ns/1ns
module sars_host (
   input wire logic i_clock,
   output logic o_select_n,
   output logic o_io_clock
);
   initial begin
      o_select_n = 1'b1;
      o_io_clock = 1'b1;
   end
   // Callers keep each level at least 20 cycles, above the filter time
   task automatic select_level(input logic level);
      @(posedge i_clock);
      o_select_n <= level;
   endtask : select_level
   // Rising edge follows every fall within one period, so no long stall
   task automatic shift_pulse();
      #37;
      o_io_clock = 1'b0;
      #3;
      o_io_clock = 1'b1;
   endtask : shift_pulse
endmodule : sars_host

// ---- sim/sars_sequencer_properties.sv ----
// Port-level checks of the readout sequencer.
// Assumes select moves at system clock edges, as the bench drives it.
`timescale 1ns/1ns
module sars_sequencer_properties
   import sars_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_select_n,
   input wire logic o_data_oe_n,
   input wire logic [RES_BITS-1:0] o_dac_code,
   input wire logic o_sampling,
   input wire logic o_busy
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_nrst);
   oe_enable_a: assert property ($fell(i_select_n) |-> ##[1:13] !o_data_oe_n)
      else $error("output not enabled");
   oe_disable_a: assert property ($rose(i_select_n) |-> ##[1:3] o_data_oe_n)
      else $error("output not released");
   filter_hold_a: assert property ($fell(i_select_n) && !o_busy |-> !o_busy [*8])
      else $error("select accepted too early");
   busy_select_a: assert property ($rose(o_busy) |-> !i_select_n && !o_data_oe_n)
      else $error("cycle without select");
   sample_busy_a: assert property (o_sampling |-> o_busy && !o_data_oe_n)
      else $error("sampling outside access");
   convert_start_a: assert property ($fell(o_sampling) && o_busy |->
      ##[0:4] o_dac_code == 10'h200)
      else $error("conversion did not start");
   convert_time_a: assert property ($fell(o_sampling) && o_busy |-> ##[1:210] !o_busy)
      else $error("conversion too long");
   step_hold_a: assert property ($changed(o_dac_code) && !o_sampling && o_busy |=>
      $stable(o_dac_code) [*8])
      else $error("trial step too short");
   oe_seen_c: cover property ($fell(o_data_oe_n));
   done_seen_c: cover property ($fell(o_busy));
   sample_seen_c: cover property ($rose(o_sampling));
   abort_seen_c: cover property (o_busy && $fell(i_select_n) ##[1:20] !o_busy);
endmodule : sars_sequencer_properties
bind sars_sequencer sars_sequencer_properties chk (.i_clock(i_clock), .i_nrst(i_nrst),
   .i_select_n(i_select_n), .o_data_oe_n(o_data_oe_n), .o_dac_code(o_dac_code),
   .o_sampling(o_sampling), .o_busy(o_busy));

// ---- sim/sars_sequencer_tb.sv ----
// Self-checking bench: host model, comparator model and expected result per frame.
// Assumes every host falling edge after link enable counts; about 201 cycles to convert.
`timescale 1ns/1ns
module sars_sequencer_tb;
   import sars_pkg::*;
   logic i_clock, i_nrst, i_above_ref, i_below_ref, i_cmp_high, sel_n, io_clk;
   logic o_data, o_data_oe_n, o_sampling, o_busy;
   logic [RES_BITS-1:0] vin, exp_res, o_dac_code;
   int res_q[$];
   int err_total = 0;
   int comparisons = 0;
   int cycles = 0;
   // Held input sits half a step above vin, so the trial wins on equality
   assign i_cmp_high = (vin >= o_dac_code);
   sars_host host (.i_clock(i_clock), .o_select_n(sel_n), .o_io_clock(io_clk));
   sars_sequencer uut (.i_clock(i_clock), .i_nrst(i_nrst), .i_io_clock(io_clk),
      .i_select_n(sel_n), .i_cmp_high(i_cmp_high), .i_above_ref(i_above_ref),
      .i_below_ref(i_below_ref), .o_data(o_data), .o_data_oe_n(o_data_oe_n),
      .o_dac_code(o_dac_code), .o_sampling(o_sampling), .o_busy(o_busy));
   task automatic check(input logic [RES_BITS-1:0] seen, input logic [RES_BITS-1:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test();
      if (err_total == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test
   task automatic tick(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask : tick
   // Reset clears the held result, so the model restarts from a zero result
   task automatic reset_pulse();
      i_nrst <= 1'b0;
      repeat (4) @(posedge i_clock);
      i_nrst <= 1'b1;
      res_q = {0};
      tick(5);
      check(o_data_oe_n, 1);
      check(o_busy, 0);
      check(o_data, 0);
   endtask : reset_pulse
   // One frame reads the previous result and starts a new conversion
   task automatic frame(input logic [RES_BITS-1:0] v, input logic hi, input logic lo,
                        input bit early, input bit abort);
      int n;
      exp_res = RES_BITS'(res_q[$]);
      host.select_level(1'b0);
      vin <= v;
      i_above_ref <= hi;
      i_below_ref <= lo;
      tick(4);
      if (early) repeat (3) host.shift_pulse();
      tick(25);
      check(o_data_oe_n, 0);
      check(o_busy, 1);
      check(o_sampling, 0);
      check(o_data, exp_res[RES_BITS-1]);
      for (int k = 1; k <= RES_BITS; k++) begin
         host.shift_pulse();
         tick(6);
         check(o_sampling, (k >= 3 && k <= 9));
         if (k < RES_BITS) check(o_data, exp_res[RES_BITS-1-k]);
         else check(o_data, 0);
      end
      host.select_level(1'b1);
      if (abort) begin
         tick(20);
         host.select_level(1'b0);
         tick(20);
         host.select_level(1'b1);
         tick(40);
         check(o_busy, 0);
      end else begin
         n = 0;
         while (o_busy === 1'b1 && n < 300) begin
            tick(1);
            n++;
         end
         check(n <= CONV_CYC, 1);
         res_q.push_back(hi ? CODE_ONES : (lo ? CODE_ZEROS : v));
         tick(20);
      end
      check(o_data_oe_n, 1);
   endtask : frame
   initial begin
      i_clock = 1'b0;
      forever #50 i_clock = ~i_clock;
   end
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 30000) begin
         err_total++;
         finish_test();
      end
   end
   initial begin
      i_nrst = 1'b0;
      vin = 10'h000;
      exp_res = 10'h000;
      i_above_ref = 1'b0;
      i_below_ref = 1'b0;
      void'($urandom(78168));
      reset_pulse();
      frame(10'h2A5, 0, 0, 0, 0);
      for (int i = 0; i < 4; i++) frame(RES_BITS'($urandom), 0, 0, i == 1, 0);
      for (int i = 0; i < 3; i++) frame(RES_BITS'($urandom), i != 1, i != 0, 0, 0);
      frame(RES_BITS'($urandom), 0, 0, 0, 1);
      frame(10'h3FF, 0, 0, 0, 0);
      reset_pulse();
      frame(10'h000, 0, 0, 0, 0);
      frame(10'h155, 0, 0, 0, 0);
      finish_test();
   end
endmodule : sars_sequencer_tb
